// File: verilog/vsfc_top.sv
// Purpose: valley switching and frequency reduction control
// Assumes: comparator results arrive as digital levels
// Notes:   wishbone classic slave, 32 bit data, one word per register
// How it works
// - supply on: stop charging, start soft start
// - soft start 12ms, four steps, 0.32V to 1V
// - counters turn on, current comparator turns off
// - load counter selects the turn-on valley
// - load counter updates once per 48ms period
// - feedback always below low zone: increment
// - above low zone only: hold value
// - above high zone only: decrement
// - above fast reset level: force to one
// - load counter stays within one to seven
// - load counter starts at one
// - zone thresholds shift with line voltage
// - valley counter stays within zero to seven
// - each falling aux crossing while off counts one valley
// - valley counter clears when gate rises
// - overvoltage while off latches off after blanking
// - ringing suppression, long or short by aux
// - after suppression, valleys reaching load turn on
// - maximum off time forces turn on
`timescale 1ns/1ns
module vsfc_top
  import vsfc_pkg::*;
#(
  parameter int EVAL_CYCLES = EVAL_CYC,
  parameter int SS_CYCLES   = SS_STEP_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        supply_on_i,
  input  wire logic        fb_above_low_i,
  input  wire logic        fb_above_high_i,
  input  wire logic        fb_above_reset_i,
  input  wire logic        valley_sense_input_i,
  input  wire logic        ovp_above_i,
  input  wire logic        ring_sel_above_i,
  input  wire logic        cs_trip_i,
  input  wire logic        line_high_i,
  output logic             gate_drive_output_o,
  output logic             startup_charge_o,
  output logic [9:0]       cs_limit_mv_o,
  output logic             zone_shift_o,
  output logic             latched_off_o
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (EVAL_CYCLES < 4 || EVAL_CYCLES >= (1 << 24))
    $error("evaluation period out of range");
  if (SS_CYCLES < 2 || SS_CYCLES >= (1 << 24))
    $error("soft start step out of range");

  function automatic logic [2:0] sat_inc(input logic [2:0] v, input logic [2:0] lim);
    sat_inc = (v >= lim) ? lim : v + 3'h1;
  endfunction

  // ****************************************************************
  // reset release and input synchronisers
  // ****************************************************************
  logic [1:0] rst_sh_ff;
  logic       rst_n;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rst_sh_ff <= 2'h0;
    else           rst_sh_ff <= {rst_sh_ff[0], 1'b1};
  end
  assign rst_n = rst_sh_ff[1];

  logic [8:0] raw_in;
  logic [8:0] syn;
  assign raw_in = {line_high_i, cs_trip_i, ring_sel_above_i, ovp_above_i,
                   valley_sense_input_i, fb_above_reset_i, fb_above_high_i,
                   fb_above_low_i, supply_on_i};
  // every comparator is synchronised before use
  vsfc_sync #(.WIDTH(9)) u_sync (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n),
    .d_i     (raw_in),
    .q_o     (syn)
  );
  wire s_supply = syn[0];
  wire s_low    = syn[1];
  wire s_high   = syn[2];
  wire s_frst   = syn[3];
  wire s_zc     = syn[4];
  wire s_ovp    = syn[5];
  wire s_rsel   = syn[6];
  wire s_trip   = syn[7];
  wire s_line   = syn[8];

  // ****************************************************************
  // register interface
  // ****************************************************************
  logic        ctrl_en_ff;
  vsfc_state_e state_ff, nxt_state;
  logic [2:0]  load_ff, valley_ff;
  logic [1:0]  ss_step_ff;
  logic        ss_done_ff;
  wire         wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire         wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADR_CTRL);
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0;
    if (wb_adr_i == ADR_CTRL) rd_data[CTRL_EN] = ctrl_en_ff;
    if (wb_adr_i == ADR_STATUS) begin
      rd_data[ST_LOAD_LSB +: 3]   = load_ff;
      rd_data[ST_VALLEY_LSB +: 3] = valley_ff;
      rd_data[ST_STATE_LSB +: 3]  = state_ff;
      rd_data[ST_SS_LSB +: 2]     = ss_step_ff;
      rd_data[ST_SSDONE]          = ss_done_ff;
      rd_data[ST_LATCHED]         = (state_ff == ST_LATCH);
    end
  end
  // one cycle ack, unmapped addresses read zero
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0;
      ctrl_en_ff <= CTRL_EN_RST;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0;
      if (wr_ctrl) ctrl_en_ff <= wb_dat_i[CTRL_EN];
    end
  end

  // ****************************************************************
  // soft start: four timed current limit steps
  // ****************************************************************
  logic [23:0] ss_cnt_ff;
  wire         running = (state_ff != ST_IDLE) && (state_ff != ST_LATCH);
  wire         ss_tick = running & ~ss_done_ff & (ss_cnt_ff == 24'(SS_CYCLES - 1));
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ss_cnt_ff  <= 24'h0;
      ss_step_ff <= 2'h0;
      ss_done_ff <= 1'b0;
    end else if (!running) begin
      ss_cnt_ff  <= 24'h0;
      ss_step_ff <= 2'h0;
      ss_done_ff <= 1'b0;
    end else if (!ss_done_ff) begin
      ss_cnt_ff <= ss_tick ? 24'h0 : ss_cnt_ff + 24'h1;
      if (ss_tick && ss_step_ff == SS_LAST) ss_done_ff <= 1'b1;
      else if (ss_tick) ss_step_ff <= ss_step_ff + 2'h1;
    end
  end
  wire [9:0] ss_level = ss_done_ff ? CS_FINAL_MV :
                        ((ss_step_ff == SS_LAST) ? CS_FINAL_MV :
                         CS_FIRST_MV + 10'(ss_step_ff * CS_STEP_MV));

  // ****************************************************************
  // evaluation period and sticky zone flags
  // ****************************************************************
  logic [23:0] ev_cnt_ff;
  logic        f_low_ff, f_high_ff, f_rst_ff;
  wire         ev_tick = running & (ev_cnt_ff == 24'(EVAL_CYCLES - 1));
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ev_cnt_ff <= 24'h0;
      f_low_ff  <= 1'b0;
      f_high_ff <= 1'b0;
      f_rst_ff  <= 1'b0;
    end else begin
      ev_cnt_ff <= (ev_tick | ~running) ? 24'h0 : ev_cnt_ff + 24'h1;
      // a new period restarts from the present input, so no crossing is lost
      f_low_ff  <= (ev_tick ? 1'b0 : f_low_ff)  | (running & s_low);
      f_high_ff <= (ev_tick ? 1'b0 : f_high_ff) | (running & s_high);
      f_rst_ff  <= (ev_tick ? 1'b0 : f_rst_ff)  | (running & s_frst);
    end
  end

  // ****************************************************************
  // load counter
  // ****************************************************************
  logic [2:0] nxt_load;
  always_comb begin
    nxt_load = load_ff;
    if (!running) nxt_load = LOAD_MIN;
    else if (ev_tick) begin
      if (f_rst_ff) nxt_load = LOAD_MIN;
      else if (f_high_ff)
        nxt_load = (load_ff <= LOAD_MIN) ? LOAD_MIN : load_ff - 3'h1;
      else if (!f_low_ff) nxt_load = sat_inc(load_ff, LOAD_MAX);
    end                                                      // hold otherwise
  end
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) load_ff <= LOAD_MIN;
    else        load_ff <= nxt_load;
  end

  // ****************************************************************
  // valley counter and off-time timers
  // ****************************************************************
  logic        zc_prev_ff;
  logic [11:0] off_cnt_ff, ring_cnt_ff, ovp_cnt_ff;
  logic        gate_ff;
  wire         off_phase = (state_ff == ST_RING) || (state_ff == ST_HUNT);
  wire         zc_fall   = zc_prev_ff & ~s_zc & off_phase;
  wire         ring_done = (ring_cnt_ff == 12'h0);
  wire         max_off   = (off_cnt_ff == 12'(MAX_OFF_CYC));
  wire         ovp_trip  = (ovp_cnt_ff == 12'(OVP_BLK_CYC));
  wire         turn_on   = (state_ff == ST_HUNT) & ((valley_ff >= load_ff) | max_off);
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      zc_prev_ff  <= 1'b0;
      valley_ff   <= 3'h0;
      off_cnt_ff  <= 12'h0;
      ring_cnt_ff <= 12'h0;
      ovp_cnt_ff  <= 12'h0;
    end else begin
      zc_prev_ff <= s_zc;
      if (nxt_state == ST_ON) valley_ff <= 3'h0;
      else if (zc_fall) valley_ff <= sat_inc(valley_ff, VALLEY_MAX);
      off_cnt_ff <= (off_phase && !max_off) ? off_cnt_ff + 12'h1 :
                    (off_phase ? off_cnt_ff : 12'h0);
      if (state_ff == ST_ON && s_trip)
        ring_cnt_ff <= s_rsel ? 12'(RING_S_CYC - 1) : 12'(RING_L_CYC - 1);
      else if (!ring_done) ring_cnt_ff <= ring_cnt_ff - 12'h1;
      ovp_cnt_ff <= (off_phase && s_ovp && !ovp_trip) ? ovp_cnt_ff + 12'h1 :
                    ((off_phase && s_ovp) ? ovp_cnt_ff : 12'h0);
    end
  end

  // ****************************************************************
  // switching state machine
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:  if (s_supply && ctrl_en_ff) nxt_state = ST_ON;
      ST_ON:    if (s_trip) nxt_state = ST_RING;
      ST_RING:  if (ovp_trip) nxt_state = ST_LATCH;
                else if (ring_done) nxt_state = ST_HUNT;
      ST_HUNT:  if (ovp_trip) nxt_state = ST_LATCH;
                else if (turn_on) nxt_state = ST_ON;
      ST_LATCH: nxt_state = ST_LATCH;
      default:  nxt_state = ST_IDLE;
    endcase
    if (state_ff != ST_LATCH && !ctrl_en_ff) nxt_state = ST_IDLE;
  end

  // outputs straight from flops
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff            <= ST_IDLE;
      gate_ff             <= 1'b0;
      startup_charge_o    <= 1'b1;
      cs_limit_mv_o       <= CS_FIRST_MV;
      zone_shift_o        <= 1'b0;
      latched_off_o       <= 1'b0;
    end else begin
      state_ff         <= nxt_state;
      gate_ff          <= (nxt_state == ST_ON);
      startup_charge_o <= (nxt_state == ST_IDLE);
      cs_limit_mv_o    <= ss_level;
      zone_shift_o     <= s_line;
      latched_off_o    <= (nxt_state == ST_LATCH);
    end
  end
  assign gate_drive_output_o = gate_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  AST_LOAD_RANGE: assert property (load_ff >= LOAD_MIN && load_ff <= LOAD_MAX)
    else $error("load counter out of range");
  AST_VALLEY_CLR: assert property ($rose(gate_ff) |-> valley_ff == 3'h0)
    else $error("valley counter not cleared at turn on");
  AST_RING_OFF: assert property (state_ff == ST_RING |-> !gate_ff)
    else $error("gate on during ringing suppression");
  AST_TURN_ON: assert property (state_ff == ST_HUNT && valley_ff >= load_ff && !ovp_trip
    && ctrl_en_ff |=> gate_ff)
    else $error("missed valley turn on");
  AST_MAX_OFF: assert property (state_ff == ST_HUNT && max_off && !ovp_trip && ctrl_en_ff
    |=> gate_ff)
    else $error("maximum off time not enforced");
  AST_FAST_RST: assert property (ev_tick && f_rst_ff |=> load_ff == LOAD_MIN)
    else $error("fast reset did not set load to one");
  AST_INC: assert property (ev_tick && !f_low_ff && !f_high_ff && !f_rst_ff
    && load_ff < LOAD_MAX |=> load_ff == $past(load_ff) + 3'h1)
    else $error("load counter did not increment");
  AST_HOLD: assert property (ev_tick && f_low_ff && !f_high_ff && !f_rst_ff
    |=> load_ff == $past(load_ff))
    else $error("load counter changed in hold zone");
  AST_LATCH: assert property (latched_off_o |=> latched_off_o && !gate_ff)
    else $error("latch off released");
  AST_CHARGE: assert property (gate_ff |-> !startup_charge_o)
    else $error("charging path on while switching");

endmodule // vsfc_top

// File: verilog/vsfc_pkg.sv
// Purpose: shared constants and types of the valley switching controller
// Assumes: 50 MHz system clock
// Notes:   times are kept in their own unit, cycle counts derive from them
package vsfc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_MHZ         = 50;
  localparam int T_EVAL_US       = 48000;  // load evaluation period
  localparam int T_SOFTSTART_US  = 12000;  // whole soft start
  localparam int SS_STEPS        = 4;
  localparam int T_RING_LONG_NS  = 2500;   // suppression, aux below select level
  localparam int T_RING_SHORT_NS = 1000;   // suppression, aux above select level
  localparam int T_MAX_OFF_NS    = 50000;  // longest off time
  localparam int T_OVP_BLANK_NS  = 1000;   // overvoltage blanking
  // least times round up, longest times round down
  localparam int EVAL_CYC     = T_EVAL_US * CLK_MHZ;
  localparam int SS_STEP_CYC  = (T_SOFTSTART_US / SS_STEPS) * CLK_MHZ;
  localparam int RING_L_CYC   = (T_RING_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int RING_S_CYC   = (T_RING_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int MAX_OFF_CYC  = (T_MAX_OFF_NS * CLK_MHZ) / 1000;
  localparam int OVP_BLK_CYC  = (T_OVP_BLANK_NS * CLK_MHZ + 999) / 1000;

  // ****************************************************************
  // current limit levels during soft start, in millivolts
  // ****************************************************************
  localparam logic [9:0] CS_FIRST_MV = 10'd320;
  localparam logic [9:0] CS_FINAL_MV = 10'd1000;
  localparam logic [9:0] CS_STEP_MV  = 10'd226;
  localparam logic [1:0] SS_LAST     = 2'h3;

  // ****************************************************************
  // counters
  // ****************************************************************
  localparam logic [2:0] LOAD_MIN   = 3'h1;
  localparam logic [2:0] LOAD_MAX   = 3'h7;
  localparam logic [2:0] VALLEY_MAX = 3'h7;

  // ****************************************************************
  // wishbone register map and fields
  // ****************************************************************
  localparam logic [3:0] ADR_CTRL   = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam int         CTRL_EN    = 0;
  localparam logic       CTRL_EN_RST = 1'b1;
  localparam int ST_LOAD_LSB   = 0;
  localparam int ST_VALLEY_LSB = 4;
  localparam int ST_STATE_LSB  = 8;
  localparam int ST_SS_LSB     = 12;
  localparam int ST_SSDONE     = 14;
  localparam int ST_LATCHED    = 15;

  // switching state, gray along ready, on, ring, hunt, latched
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ON    = 3'b001,
    ST_RING  = 3'b011,
    ST_HUNT  = 3'b010,
    ST_LATCH = 3'b110
  } vsfc_state_e;

endpackage

// File: verilog/vsfc_sync.sv
// Purpose: two flop synchroniser for a group of comparator levels
// Assumes: inputs are levels, each bit crosses on its own
// Notes:   the first stage is read only by the second stage
`timescale 1ns/1ns
module vsfc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_ff;

  // ****************************************************************
  // two stage capture
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      q_o     <= '0;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end

endmodule // vsfc_sync

// File: dv/vsfc_plant.sv
// Purpose: far side model, current comparator and ringing aux winding
// Assumes: gate drive comes from the controller, one clock
// Notes:   damped_i stops the ringing so no valley is ever seen
`timescale 1ns/1ns
module vsfc_plant #(
  parameter int ON_CYC = 30,
  parameter int HALF   = 10
) (
  input  wire logic clk_i,
  input  wire logic gate_i,
  input  wire logic damped_i,
  output logic      cs_trip_o,
  output logic      valley_o
);
  int on_cnt = 0;
  int ring_cnt = 0;

  // ****************************************************************
  // primary current ramp and aux ringing
  // ****************************************************************
  // current ramps while on; aux is clamped low while on, rings while off
  always @(posedge clk_i) begin
    if (gate_i) begin
      on_cnt    <= on_cnt + 1;
      cs_trip_o <= (on_cnt >= ON_CYC);
      valley_o  <= 1'b0;
      ring_cnt  <= 0;
    end else begin
      on_cnt    <= 0;
      cs_trip_o <= 1'b0;
      ring_cnt  <= (ring_cnt + 1) % (2 * HALF);
      valley_o  <= !damped_i && (ring_cnt < HALF);
    end
  end
endmodule // vsfc_plant

// File: dv/tb.sv
// Purpose: self checking bench of the valley switching controller
// Assumes: short evaluation and soft start counts set by parameters
// Notes:   outputs are sampled at the rising edge, inputs driven by nba
`timescale 1ns/1ns
module tb;
  import vsfc_pkg::*;
  localparam int EVAL = 200;
  localparam int SS   = 50;
  logic        sys_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        cyc = 0, stb = 0, we = 0, supply = 0, fb_low = 1, fb_high = 0, fb_rst = 0;
  logic        ovp = 0, ring_sel = 0, line_high = 0, damped = 0;
  logic [3:0]  adr = 0;
  logic [31:0] wdat = 0, rdat;
  logic        ack, valley, trip, gate, charge, zone, latched;
  logic [9:0]  cs_limit;
  int          n_errors = 0;
  int          comparisons = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  vsfc_top #(.EVAL_CYCLES(EVAL), .SS_CYCLES(SS)) vsfc_top_i (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .supply_on_i(supply), .fb_above_low_i(fb_low),
    .fb_above_high_i(fb_high), .fb_above_reset_i(fb_rst), .valley_sense_input_i(valley),
    .ovp_above_i(ovp), .ring_sel_above_i(ring_sel), .cs_trip_i(trip),
    .line_high_i(line_high), .gate_drive_output_o(gate), .startup_charge_o(charge),
    .cs_limit_mv_o(cs_limit), .zone_shift_o(zone), .latched_off_o(latched));

  vsfc_plant vsfc_plant_i (.clk_i(sys_clk_i), .gate_i(gate), .damped_i(damped),
    .cs_trip_o(trip), .valley_o(valley));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // a wait that ran out counts as a mismatch and ends the run
  task automatic timed_out(input string what);
    n_errors++;
    $display("wrong value at %0t: timeout %s", $time, what);
    report_and_stop();
  endtask

  // classic single cycle, held until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] rd);
    int i;
    @(posedge sys_clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++)
      @(posedge sys_clk_i);
    if (i == 20)
      timed_out("bus");
    rd  = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wait_gate(input logic lvl, input int bound);
    int i;
    for (i = 0; i < bound && gate !== lvl; i++)
      @(posedge sys_clk_i);
    if (i == bound)
      timed_out("gate");
  endtask

  // cycles the gate stays low in the next off phase
  task automatic off_time(output int n);
    wait_gate(1'b1, 5000);
    wait_gate(1'b0, 5000);
    for (n = 0; n < 5000 && gate === 1'b0; n++)
      @(posedge sys_clk_i);
  endtask

  task automatic load_is(input logic [2:0] exp, input string what);
    logic [31:0] rd;
    wb_xfer(1'b0, ADR_STATUS, 32'h0, rd);
    check(rd[ST_LOAD_LSB +: 3], exp, what);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [31:0] rd;
    check(gate, 1'b0, "gate idle");
    check(charge, 1'b1, "charge path idle");
    check(cs_limit, CS_FIRST_MV, "first limit");
    load_is(LOAD_MIN, "load at start");
    wb_xfer(1'b0, ADR_STATUS, 32'h0, rd);
    check(rd[ST_VALLEY_LSB +: 3], 3'h0, "valleys at start");
    wb_xfer(1'b0, 4'h8, 32'h0, rd);
    check(rd, 32'h0, "unmapped read");
    line_high <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    check(zone, 1'b1, "zone shift high line");
    line_high <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    check(zone, 1'b0, "zone shift low line");
    $display("test reset done");
  endtask

  task automatic t_startup;
    int k;
    int n;
    logic [9:0] prev;
    supply <= 1'b1;
    wait_gate(1'b1, 10);
    check(charge, 1'b0, "charge path off");
    prev = cs_limit;
    for (k = 1; k < 4; k++) begin
      for (n = 0; n < 4 * SS && cs_limit === prev; n++)
        @(posedge sys_clk_i);
      prev = cs_limit;
      check(prev, (k == 3) ? CS_FINAL_MV : CS_FIRST_MV + k * CS_STEP_MV, "step");
      if (k > 1)
        check(n == SS, 1'b1, "step length");
    end
    $display("test soft start done");
  endtask

  task automatic t_ring;
    int n;
    int k;
    for (k = 0; k < 2; k++) begin
      ring_sel <= k[0];
      off_time(n);
      off_time(n);
      n = n - (k == 0 ? RING_L_CYC : RING_S_CYC);
      check(n >= 0 && n <= 8, 1'b1, "suppression length");
    end
    ring_sel <= 1'b0;
    $display("test ringing done");
  endtask

  task automatic t_ctrl;
    logic [31:0] rd;
    wb_xfer(1'b1, ADR_CTRL, 32'h0, rd);
    wait_gate(1'b0, 100);
    repeat (300) @(posedge sys_clk_i);
    check(gate, 1'b0, "disabled gate");
    wb_xfer(1'b1, ADR_CTRL, 32'h1, rd);
    wait_gate(1'b1, 20);
    wb_xfer(1'b0, ADR_STATUS, 32'h0, rd);
    check(rd[ST_VALLEY_LSB +: 3], 3'h0, "valleys cleared on turn on");
    $display("test control done");
  endtask

  task automatic t_load;
    time t1;
    int d;
    logic [31:0] rd;
    int i;
    t1 = 0;
    fb_low <= 1'b0;
    for (i = 0; i < 1000; i++) begin
      wb_xfer(1'b0, ADR_STATUS, 32'h0, rd);
      if (rd[ST_LOAD_LSB +: 3] !== LOAD_MIN && t1 == 0)
        t1 = $time;
      if (rd[ST_LOAD_LSB +: 3] === 3'h3)
        break;
    end
    // signed distance, the polling grain is three cycles either way
    d = int'(($time - t1) / 20) - EVAL;
    check(d >= -4 && d <= 4, 1'b1, "period length");
    // hold is judged mid range, where saturation cannot hide it
    fb_low <= 1'b1;
    repeat (3 * EVAL) @(posedge sys_clk_i);
    load_is(3'h3, "low zone holds");
    fb_low <= 1'b0;
    repeat (6 * EVAL) @(posedge sys_clk_i);
    load_is(LOAD_MAX, "count up saturates");
    fb_low  <= 1'b1;
    fb_high <= 1'b1;
    repeat (8 * EVAL) @(posedge sys_clk_i);
    load_is(LOAD_MIN, "count down saturates");
    fb_high <= 1'b0;
    fb_low  <= 1'b0;
    repeat (8 * EVAL) @(posedge sys_clk_i);
    load_is(LOAD_MAX, "count up before fast reset");
    fb_low  <= 1'b1;
    fb_high <= 1'b1;
    fb_rst  <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    fb_high <= 1'b0;
    fb_rst  <= 1'b0;
    repeat (2 * EVAL) @(posedge sys_clk_i);
    load_is(LOAD_MIN, "fast reset");
    $display("test load counter done");
  endtask

  task automatic t_maxoff_ovp;
    int n;
    damped <= 1'b1;
    off_time(n);
    off_time(n);
    check(n >= MAX_OFF_CYC && n <= MAX_OFF_CYC + 8, 1'b1, "maximum off");
    damped <= 1'b0;
    wait_gate(1'b0, 5000);
    ovp <= 1'b1;
    for (n = 0; n < 200 && latched !== 1'b1; n++)
      @(posedge sys_clk_i);
    check(n >= OVP_BLK_CYC && n <= OVP_BLK_CYC + 8, 1'b1, "blanking");
    ovp <= 1'b0;
    repeat (3000) @(posedge sys_clk_i);
    check({latched, gate}, 2'b10, "latched off");
    $display("test max off and overvoltage done");
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    t_reset();
    t_startup();
    t_ring();
    t_ctrl();
    t_load();
    t_maxoff_ovp();
    report_and_stop();
  end
endmodule // tb
